// *** hdl/srs_pkg.sv ***
// Shared constants and types for the serial ready-signalling link
package srs_pkg;
	typedef enum logic [1:0] {
		SRS_PM_FULL = 2'b00,
		SRS_PM_MID  = 2'b01,
		SRS_PM_LOW  = 2'b10
	} srs_pmode_t;
	typedef enum logic [1:0] {
		SRS_CM_CONT   = 2'b00,
		SRS_CM_SINGLE = 2'b01,
		SRS_CM_CREAD  = 2'b10
	} srs_cmode_t;
	localparam int CLK_NS        = 20;
	localparam int CNT_W         = 12;
	// Core clock periods; the core runs on clock
	localparam int GAP_FULL_MCLK = 3;
	localparam int GAP_MID_MCLK  = 12;
	localparam int GAP_LOW_MCLK  = 24;
	localparam int RDYHI_FULL_US = 6;
	localparam int RDYHI_MID_US  = 25;
	localparam int RDYHI_LOW_US  = 50;
	localparam int SW_NS         = 10;
	localparam int SW_EXT_NS     = 110;
	localparam int SW_CYC        = (SW_NS + CLK_NS - 1) / CLK_NS;
	localparam int SW_EXT_CYC    = (SW_EXT_NS + CLK_NS - 1) / CLK_NS;
	localparam int SCLK_HALF_CYC = 8;
	localparam int CMD_W         = 8;
	localparam int DATA_W        = 24;
	localparam int CFG_W         = 8;
	localparam int CMD_RD_BIT    = 6;
	localparam logic [5:0] ADDR_CFG  = 6'h01;
	localparam logic [5:0] ADDR_DATA = 6'h02;
	localparam int CFG_PM_LSB    = 0;
	localparam int CFG_CM_LSB    = 2;
	localparam int CFG_HOLD_BIT  = 4;
	localparam int CFG_DLY_BIT   = 5;
	localparam logic [CFG_W-1:0] CFG_RST = 8'h00;
	localparam int AXI_AW        = 8;
	localparam logic [AXI_AW-1:0] REG_CTRL = 8'h00;
	localparam logic [AXI_AW-1:0] REG_TXD  = 8'h04;
	localparam logic [AXI_AW-1:0] REG_RXD  = 8'h08;
	localparam logic [AXI_AW-1:0] REG_STAT = 8'h0C;
	localparam logic [AXI_AW-1:0] REG_IRQS = 8'h10;
	localparam logic [AXI_AW-1:0] REG_IRQM = 8'h14;
	localparam int CTRL_GO       = 0;
	localparam int CTRL_SYNC     = 1;
	localparam int CTRL_PM_LSB   = 2;
	localparam int CTRL_CMD_LSB  = 8;
	localparam int STAT_BUSY     = 0;
	localparam int STAT_DOUT     = 1;
	localparam int IRQ_W         = 2;
	localparam int IRQ_DONE      = 0;
	localparam int IRQ_SYNC      = 1;
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;

	function automatic logic [CNT_W-1:0] srs_gap_cyc(srs_pmode_t pm);
		case (pm)
			SRS_PM_MID: return CNT_W'(GAP_MID_MCLK);
			SRS_PM_LOW: return CNT_W'(GAP_LOW_MCLK);
			default:    return CNT_W'(GAP_FULL_MCLK);
		endcase
	endfunction

	function automatic logic [CNT_W-1:0] srs_rdyhi_cyc(srs_pmode_t pm);
		case (pm)
			SRS_PM_MID: return CNT_W'(RDYHI_MID_US * 1000 / CLK_NS);
			SRS_PM_LOW: return CNT_W'(RDYHI_LOW_US * 1000 / CLK_NS);
			default:    return CNT_W'(RDYHI_FULL_US * 1000 / CLK_NS);
		endcase
	endfunction
endpackage

// *** hdl/srs_link_if.sv ***
// Serial link between the converter end and the host controller end
`timescale 1ns/1ns
interface srs_link_if;
	logic sclk;
	logic csN;
	logic din;
	logic syncN;
	logic doutO;
	logic doutOeN;
	wire  dout;

	// Pull-up while the device releases the pin
	assign dout = doutOeN ? 1'b1 : doutO;

	modport dev (
		input  sclk,
		input  csN,
		input  din,
		input  syncN,
		output doutO,
		output doutOeN
	);
	modport host (
		output sclk,
		output csN,
		output din,
		output syncN,
		input  dout
	);
endinterface

// *** hdl/srs_device.sv ***
// Converter end: serial port with shared data and ready output
`timescale 1ns/1ns
module srs_device
	import srs_pkg::*;
(
	input  logic              clock,
	input  logic              nrst,
	srs_link_if.dev           link,
	input  logic              convValid,
	input  logic [DATA_W-1:0] convData,
	output srs_pmode_t        cfgPowerMode,
	output srs_cmode_t        cfgConvMode,
	output logic              syncStart,
	output logic              resultTaken,
	output logic              readyN
);
	typedef enum logic [2:0] {
		D_IDLE = 3'b000,
		D_CMD  = 3'b001,
		D_DATA = 3'b010,
		D_TAIL = 3'b011,
		D_DONE = 3'b100
	} srs_dstate_t;

	localparam int NIN = 4;
	localparam int I_SCLK = 3;
	localparam int I_CS   = 2;
	localparam int I_DIN  = 1;
	localparam int I_SYNC = 0;

	logic [NIN-1:0]     pins;
	logic [NIN-1:0]     meta_r;
	logic [NIN-1:0]     sync_r;
	logic               sclkD_r;
	logic               syncD_r;
	srs_dstate_t        state_r;
	logic [4:0]         bitCnt_r;
	logic [CMD_W-1:0]   cmdSh_r;
	logic [CFG_W-1:0]   rxSh_r;
	logic               isRead_r;
	logic               isWrite_r;
	logic [DATA_W-1:0]  txSh_r;
	logic               doutO_r;
	logic               doutOeN_r;
	logic [CFG_W-1:0]   cfg_r;
	logic               rdyN_r;
	logic [DATA_W-1:0]  held_r;
	logic [DATA_W-1:0]  pend_r;
	logic               pendV_r;
	logic [CNT_W-1:0]   hiCnt_r;
	logic               consumed_r;
	logic [2:0]         tailCnt_r;
	logic               syncStart_r;
	logic               resultTaken_r;
	logic               rise;
	logic               fall;
	logic               csHigh;
	logic [CMD_W-1:0]   cmdFull;
	logic               lastBit;
	logic               rdDone;
	logic               hold;
	logic [2:0]         swCyc;

	assign pins = {link.sclk, link.csN, link.din, link.syncN};

	// Pins come from another clock domain
	generate
		for (genvar i = 0; i < NIN; i++)
		begin : g_sync
			always_ff @(posedge clock or negedge nrst)
			begin
				if (!nrst)
				begin
					meta_r[i] <= 1'b1;
					sync_r[i] <= 1'b1;
				end
				else
				begin
					meta_r[i] <= pins[i];
					sync_r[i] <= meta_r[i];
				end
			end
		end
	endgenerate

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			sclkD_r <= 1'b1;
			syncD_r <= 1'b1;
		end
		else
		begin
			sclkD_r <= sync_r[I_SCLK];
			syncD_r <= sync_r[I_SYNC];
		end
	end

	assign rise    = sync_r[I_SCLK] & ~sclkD_r;
	assign fall    = ~sync_r[I_SCLK] & sclkD_r;
	assign csHigh  = sync_r[I_CS];
	assign cmdFull = {cmdSh_r[CMD_W-2:0], sync_r[I_DIN]};
	assign lastBit = isRead_r ? (bitCnt_r == 5'(DATA_W - 1))
		: (bitCnt_r == 5'(CFG_W - 1));
	assign rdDone  = (state_r == D_DATA) & rise & lastBit & isRead_r;
	assign hold    = cfg_r[CFG_HOLD_BIT];
	assign swCyc   = cfg_r[CFG_DLY_BIT] ? 3'(SW_EXT_CYC) : 3'(SW_CYC);

	// Transfer sequencing; deselect aborts any phase
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			state_r   <= D_IDLE;
			bitCnt_r  <= 5'h00;
			cmdSh_r   <= 8'h00;
			rxSh_r    <= 8'h00;
			isRead_r  <= 1'b0;
			isWrite_r <= 1'b0;
			tailCnt_r <= 3'h0;
		end
		else if (csHigh)
			state_r <= D_IDLE;
		else
		begin
			case (state_r)
				D_IDLE:
				begin
					state_r  <= D_CMD;
					bitCnt_r <= 5'h00;
				end
				D_CMD:
					if (rise)
					begin
						cmdSh_r  <= cmdFull;
						bitCnt_r <= bitCnt_r + 5'h01;
						if (bitCnt_r == 5'(CMD_W - 1))
						begin
							bitCnt_r  <= 5'h00;
							isRead_r  <= cmdFull[CMD_RD_BIT]
								& (cmdFull[5:0] == ADDR_DATA);
							isWrite_r <= ~cmdFull[CMD_RD_BIT]
								& (cmdFull[5:0] == ADDR_CFG);
							if (cmdFull[5:0] == ADDR_DATA
								|| cmdFull[5:0] == ADDR_CFG)
								state_r <= D_DATA;
							else
								state_r <= D_DONE;
						end
					end
				D_DATA:
					if (rise)
					begin
						rxSh_r   <= {rxSh_r[CFG_W-2:0], sync_r[I_DIN]};
						bitCnt_r <= bitCnt_r + 5'h01;
						if (lastBit)
						begin
							state_r   <= D_TAIL;
							tailCnt_r <= 3'h1;
						end
					end
				D_TAIL:
					// Held until deselect when hold is set on a read
					if (!hold || !isRead_r)
					begin
						tailCnt_r <= tailCnt_r + 3'h1;
						if (tailCnt_r >= swCyc || !isRead_r)
							state_r <= D_DONE;
					end
				default:
					state_r <= state_r;
			endcase
		end
	end

	// Data launched on falling edges and held through a read's tail, ready shown otherwise
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			txSh_r  <= 24'h00_0000;
			doutO_r <= 1'b1;
		end
		else if (state_r == D_CMD && rise
			&& bitCnt_r == 5'(CMD_W - 1))
			// Continuous read never repeats a word
			txSh_r <= (cfg_r[CFG_CM_LSB +: 2] == SRS_CM_CREAD
				&& consumed_r) ? '1 : held_r;
		else if (state_r == D_DATA && isRead_r)
		begin
			if (fall)
			begin
				doutO_r <= txSh_r[DATA_W-1];
				txSh_r  <= {txSh_r[DATA_W-2:0], 1'b0};
			end
		end
		else if (state_r == D_TAIL && isRead_r)
			doutO_r <= doutO_r;
		else
			doutO_r <= rdyN_r;
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			doutOeN_r <= 1'b1;
		else
			doutOeN_r <= csHigh;
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			cfg_r <= CFG_RST;
		else if (state_r == D_DATA && rise && lastBit && isWrite_r)
			cfg_r <= {rxSh_r[CFG_W-2:0], sync_r[I_DIN]};
	end

	// Ready flag; a new result wins over a read finishing
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			rdyN_r     <= 1'b1;
			held_r     <= 24'h00_0000;
			pend_r     <= 24'h00_0000;
			pendV_r    <= 1'b0;
			hiCnt_r    <= 12'h000;
			consumed_r <= 1'b0;
		end
		else
		begin
			if (rdDone)
			begin
				rdyN_r     <= 1'b1;
				consumed_r <= 1'b1;
			end
			if (pendV_r)
			begin
				hiCnt_r <= hiCnt_r - 12'h001;
				if (hiCnt_r == 12'h001)
				begin
					pendV_r    <= 1'b0;
					held_r     <= pend_r;
					rdyN_r     <= 1'b0;
					consumed_r <= 1'b0;
				end
			end
			if (convValid)
			begin
				if (!rdyN_r || pendV_r)
				begin
					// Unread result is displaced by a high pulse
					rdyN_r  <= 1'b1;
					pend_r  <= convData;
					pendV_r <= 1'b1;
					hiCnt_r <= srs_rdyhi_cyc(
						srs_pmode_t'(cfg_r[CFG_PM_LSB +: 2]));
				end
				else
				begin
					held_r     <= convData;
					rdyN_r     <= 1'b0;
					consumed_r <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			syncStart_r   <= 1'b0;
			resultTaken_r <= 1'b0;
		end
		else
		begin
			syncStart_r   <= sync_r[I_SYNC] & ~syncD_r;
			resultTaken_r <= rdDone;
		end
	end

	assign link.doutO   = doutO_r;
	assign link.doutOeN = doutOeN_r;
	assign cfgPowerMode = srs_pmode_t'(cfg_r[CFG_PM_LSB +: 2]);
	assign cfgConvMode  = srs_cmode_t'(cfg_r[CFG_CM_LSB +: 2]);
	assign syncStart    = syncStart_r;
	assign resultTaken  = resultTaken_r;
	assign readyN       = rdyN_r;
endmodule // srs_device

// *** hdl/srs_host.sv ***
// Host end: AXI4-Lite controlled serial master
`timescale 1ns/1ns
module srs_host
	import srs_pkg::*;
(
	input  logic              clock,
	input  logic              nrst,
	srs_link_if.host          link,
	input  logic [AXI_AW-1:0] awaddr,
	input  logic              awvalid,
	output logic              awready,
	input  logic [31:0]       wdata,
	input  logic [3:0]        wstrb,
	input  logic              wvalid,
	output logic              wready,
	output logic [1:0]        bresp,
	output logic              bvalid,
	input  logic              bready,
	input  logic [AXI_AW-1:0] araddr,
	input  logic              arvalid,
	output logic              arready,
	output logic [31:0]       rdata,
	output logic [1:0]        rresp,
	output logic              rvalid,
	input  logic              rready,
	output logic              irq
);
	typedef enum logic [2:0] {
		H_IDLE  = 3'b000,
		H_LEAD  = 3'b001,
		H_SHIFT = 3'b010,
		H_TRAIL = 3'b011,
		H_GAP   = 3'b100,
		H_SYNC  = 3'b101
	} srs_hstate_t;

	srs_hstate_t        state_r;
	logic [CNT_W-1:0]   cnt_r;
	logic [5:0]         bit_r;
	logic [5:0]         nBits_r;
	logic [31:0]        tx_r;
	logic [DATA_W-1:0]  rx_r;
	logic               sclk_r, csN_r, din_r, syncN_r;
	logic [1:0]         doutS_r;
	logic [AXI_AW-1:0]  awa_r;
	logic [31:0]        wd_r;
	logic               awH_r, wH_r, bvalid_r, rvalid_r, arready_r;
	logic [1:0]         bresp_r, rresp_r;
	logic [31:0]        rdata_r;
	logic [1:0]         pm_r;
	logic [CMD_W-1:0]   cmd_r;
	logic [CFG_W-1:0]   txd_r;
	logic [IRQ_W-1:0]   irqS_r, irqM_r, irqSet;
	logic               irq_r, goReq, syncReq, wrDo, halfDone;

	assign wrDo     = awH_r & wH_r & ~bvalid_r;
	assign goReq    = wrDo & (awa_r == REG_CTRL) & wd_r[CTRL_GO];
	assign syncReq  = wrDo & (awa_r == REG_CTRL) & wd_r[CTRL_SYNC];
	assign halfDone = cnt_r == CNT_W'(SCLK_HALF_CYC - 1);

	// One driver for the whole event vector
	always_comb
	begin
		irqSet           = '0;
		irqSet[IRQ_DONE] = state_r == H_TRAIL && halfDone;
		irqSet[IRQ_SYNC] = state_r == H_SYNC
			&& cnt_r == srs_gap_cyc(srs_pmode_t'(pm_r));
	end

	// Write channel: address and data accepted in either order
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			awH_r <= 1'b0; wH_r <= 1'b0; bvalid_r <= 1'b0;
			awa_r <= 8'h00; wd_r <= 32'h0000_0000; bresp_r <= RESP_OKAY;
		end
		else
		begin
			if (awvalid && !awH_r)
			begin
				awH_r <= 1'b1; awa_r <= awaddr;
			end
			if (wvalid && !wH_r)
			begin
				wH_r <= 1'b1; wd_r <= wdata;
			end
			if (wrDo)
			begin
				awH_r <= 1'b0; wH_r <= 1'b0; bvalid_r <= 1'b1;
				if (awa_r == REG_CTRL || awa_r == REG_TXD
					|| awa_r == REG_IRQS || awa_r == REG_IRQM)
					bresp_r <= RESP_OKAY;
				else
					bresp_r <= RESP_SLVERR;
			end
			else if (bvalid_r && bready)
				bvalid_r <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			pm_r <= 2'b00; cmd_r <= 8'h00; txd_r <= 8'h00;
			irqM_r <= 2'b00;
		end
		else if (wrDo && wstrb != 4'h0)
		begin
			if (awa_r == REG_CTRL && state_r == H_IDLE)
			begin
				pm_r  <= wd_r[CTRL_PM_LSB +: 2];
				cmd_r <= wd_r[CTRL_CMD_LSB +: CMD_W];
			end
			else if (awa_r == REG_TXD)
				txd_r <= wd_r[CFG_W-1:0];
			else if (awa_r == REG_IRQM)
				irqM_r <= wd_r[IRQ_W-1:0];
		end
	end

	// Sticky events; a set in the clearing cycle survives
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			irqS_r <= 2'b00;
		else if (wrDo && awa_r == REG_IRQS)
			irqS_r <= (irqS_r & ~wd_r[IRQ_W-1:0]) | irqSet;
		else
			irqS_r <= irqS_r | irqSet;
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			irq_r <= 1'b0;
		else
			irq_r <= |(irqS_r & irqM_r);
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			arready_r <= 1'b1; rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000; rresp_r <= RESP_OKAY;
		end
		else if (arvalid && arready_r)
		begin
			arready_r <= 1'b0; rvalid_r <= 1'b1; rresp_r <= RESP_OKAY;
			if (araddr == REG_CTRL)
				rdata_r <= 32'({cmd_r, 4'h0, pm_r, 2'b00});
			else if (araddr == REG_TXD)
				rdata_r <= 32'(txd_r);
			else if (araddr == REG_RXD)
				rdata_r <= 32'(rx_r);
			else if (araddr == REG_STAT)
				rdata_r <= 32'({doutS_r[1], state_r != H_IDLE});
			else if (araddr == REG_IRQS)
				rdata_r <= 32'(irqS_r);
			else if (araddr == REG_IRQM)
				rdata_r <= 32'(irqM_r);
			else
			begin
				rdata_r <= 32'h0000_0000; rresp_r <= RESP_SLVERR;
			end
		end
		else if (rvalid_r && rready)
		begin
			rvalid_r <= 1'b0; arready_r <= 1'b1;
		end
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			doutS_r <= 2'b11;
		else
			doutS_r <= {doutS_r[0], link.dout};
	end

	// Link sequencer: clock idles high, din moves on falling edges
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			state_r <= H_IDLE; cnt_r <= 12'h000; bit_r <= 6'h00;
			nBits_r <= 6'h00; tx_r <= 32'h0000_0000;
			rx_r <= 24'h00_0000; sclk_r <= 1'b1; csN_r <= 1'b1;
			din_r <= 1'b1; syncN_r <= 1'b1;
		end
		else
		begin
			cnt_r <= cnt_r + 12'h001;
			case (state_r)
				H_IDLE:
				begin
					cnt_r <= 12'h000; bit_r <= 6'h00;
					if (goReq)
					begin
						state_r <= H_LEAD; csN_r <= 1'b0;
						tx_r    <= {wd_r[CTRL_CMD_LSB +: CMD_W], txd_r,
							16'h0000};
						nBits_r <= wd_r[CTRL_CMD_LSB + CMD_RD_BIT]
							? 6'(CMD_W + DATA_W) : 6'(CMD_W + CFG_W);
					end
					else if (syncReq)
					begin
						state_r <= H_SYNC; syncN_r <= 1'b0;
					end
				end
				H_LEAD, H_SHIFT:
					if (halfDone)
					begin
						cnt_r   <= 12'h000; state_r <= H_SHIFT;
						sclk_r  <= ~sclk_r;
						if (sclk_r)
						begin
							din_r <= tx_r[31];
							tx_r  <= {tx_r[30:0], 1'b0};
						end
						else
						begin
							rx_r  <= {rx_r[DATA_W-2:0], doutS_r[1]};
							bit_r <= bit_r + 6'h01;
							if (bit_r == nBits_r - 6'h01)
								state_r <= H_TRAIL;
						end
					end
				H_TRAIL:
					if (halfDone)
					begin
						cnt_r <= 12'h000; csN_r <= 1'b1;
						din_r <= 1'b1; state_r <= H_GAP;
					end
				H_GAP:
					if (cnt_r >= srs_gap_cyc(srs_pmode_t'(pm_r)))
						state_r <= H_IDLE;
				H_SYNC:
					if (cnt_r >= srs_gap_cyc(srs_pmode_t'(pm_r)))
					begin
						syncN_r <= 1'b1; cnt_r <= 12'h000;
						state_r <= H_GAP;
					end
				default:
					state_r <= H_IDLE;
			endcase
		end
	end

	assign link.sclk  = sclk_r;
	assign link.csN   = csN_r;
	assign link.din   = din_r;
	assign link.syncN = syncN_r;
	assign awready = ~awH_r;
	assign wready  = ~wH_r;
	assign bvalid  = bvalid_r;
	assign bresp   = bresp_r;
	assign arready = arready_r;
	assign rvalid  = rvalid_r;
	assign rdata   = rdata_r;
	assign rresp   = rresp_r;
	assign irq     = irq_r;
endmodule // srs_host

// *** bench/srs_link_monitor.sv ***
// Wire-level checks on the link between the converter end and the host end
`timescale 1ns/1ns
module srs_link_monitor
(
	input logic clock,
	input logic nrst,
	input logic sclk,
	input logic csN,
	input logic din,
	input logic syncN,
	input logic doutO,
	input logic doutOeN
);
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);

	a_sclk_idle: assert property (csN |-> sclk)
		else $error("serial clock not idle high while deselected");
	a_cs_lead: assert property ($fell(csN) |-> sclk[*7])
		else $error("first clock edge too close to select");
	a_sclk_low: assert property ($fell(sclk) |-> (!sclk)[*8] ##1 sclk)
		else $error("serial clock low phase not eight cycles");
	a_sclk_high: assert property ($rose(sclk) && !csN |-> sclk[*8])
		else $error("serial clock high phase too short");
	a_din_stable: assert property ($rose(sclk) |-> $stable(din))
		else $error("input data moved on the sampling edge");
	a_dout_stable: assert property (
		$rose(sclk) && !doutOeN |-> $stable(doutO))
		else $error("output data moved on the sampling edge");
	a_gap_min: assert property ($rose(csN) |-> csN[*3])
		else $error("gap between transfers too short");
	a_sync_width: assert property ($fell(syncN) |-> (!syncN)[*3])
		else $error("sync low pulse too short");
	a_oe_release: assert property ($rose(csN) |-> ##[1:4] doutOeN)
		else $error("output not released after deselect");
	a_oe_drive: assert property ($fell(csN) |-> ##[1:4] !doutOeN)
		else $error("output not driven after select");

	c_transfer: cover property ($rose(csN));
	c_sync: cover property ($rose(syncN));
	c_release: cover property ($rose(doutOeN));
endmodule // srs_link_monitor

// *** bench/serial_port_ready_signalling_tb.sv ***
// Self-checking bench for both ends of the serial ready-signalling link
`timescale 1ns/1ns
`define CHK(nm, e, s) \
	begin \
		compares++; \
		if ((s) !== (e)) \
		begin \
			bad_count++; \
			$display("BAD %s exp %0h got %0h", nm, e, s); \
		end \
	end
module serial_port_ready_signalling_tb
	import srs_pkg::*;
;
	typedef struct packed {logic [7:0] cfg; logic [23:0] data;} srs_row_t;
	// Even data so the last bit differs from the released flag
	srs_row_t rows [4] = '{'{8'h00, 24'hA5_5A3C}, '{8'h25, 24'h12_3456},
		'{8'h12, 24'hFE_DCBA}, '{8'h08, 24'h0F_0F0E}};
	logic              clock = 1'h0;
	logic              nrst = 1'h0;
	logic              convValid = 1'h0;
	logic [DATA_W-1:0] convData = '0;
	srs_pmode_t        cfgPowerMode;
	srs_cmode_t        cfgConvMode;
	logic              syncStart, resultTaken, readyN, irq;
	logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
	logic [31:0]       wdata = '0, rdata, rd;
	logic [3:0]        wstrb = 4'hF;
	logic              awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
	logic              arvalid = 1'h0, rready = 1'h0;
	logic              awready, wready, bvalid, arready, rvalid;
	logic [1:0]        bresp, rresp, resp;
	logic              csPrev = 1'h1, sclkPrev = 1'h1;
	int                bad_count = 0, compares = 0, cycles = 0;
	int                syncCnt = 0, takenCnt = 0;
	int                rises = 0, zeroCnt = 0, afterCnt = 0;

	srs_link_if link ();
	srs_device srs_device_i (
		.clock        (clock),
		.nrst         (nrst),
		.link         (link.dev),
		.convValid    (convValid),
		.convData     (convData),
		.cfgPowerMode (cfgPowerMode),
		.cfgConvMode  (cfgConvMode),
		.syncStart    (syncStart),
		.resultTaken  (resultTaken),
		.readyN       (readyN)
	);
	srs_host srs_host_i (
		.clock   (clock),
		.nrst    (nrst),
		.link    (link.host),
		.awaddr  (awaddr),
		.awvalid (awvalid),
		.awready (awready),
		.wdata   (wdata),
		.wstrb   (wstrb),
		.wvalid  (wvalid),
		.wready  (wready),
		.bresp   (bresp),
		.bvalid  (bvalid),
		.bready  (bready),
		.araddr  (araddr),
		.arvalid (arvalid),
		.arready (arready),
		.rdata   (rdata),
		.rresp   (rresp),
		.rvalid  (rvalid),
		.rready  (rready),
		.irq     (irq)
	);
	srs_link_monitor srs_link_monitor_i (
		.clock   (clock),
		.nrst    (nrst),
		.sclk    (link.sclk),
		.csN     (link.csN),
		.din     (link.din),
		.syncN   (link.syncN),
		.doutO   (link.doutO),
		.doutOeN (link.doutOeN)
	);

	always #(CLK_NS / 2) clock = ~clock;

	always @(posedge clock)
	begin
		cycles++;
		if (syncStart)
			syncCnt++;
		if (resultTaken)
			takenCnt++;
		if (cycles == 40000)
		begin
			bad_count++;
			results();
		end
	end

	// Low cycles of the pin after the 32nd rising serial clock edge
	always @(posedge clock)
	begin
		if (!link.csN && csPrev)
		begin
			rises = 0;
			zeroCnt = 0;
			afterCnt = 0;
		end
		else if (!link.csN && link.sclk && !sclkPrev)
			rises++;
		else if (!link.csN && rises == 32)
		begin
			afterCnt++;
			if (!link.dout)
				zeroCnt++;
		end
		csPrev = link.csN;
		sclkPrev = link.sclk;
	end

	task automatic results;
		if (bad_count == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	task automatic axw(input logic [AXI_AW-1:0] a, input logic [31:0] d);
		@(posedge clock);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do
		begin
			@(posedge clock);
			if (awready)
				awvalid <= 1'h0;
			if (wready)
				wvalid <= 1'h0;
		end
		while (!bvalid);
		resp = bresp;
		bready <= 1'h0;
	endtask

	task automatic axr(input logic [AXI_AW-1:0] a);
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'h1;
		rready <= 1'h1;
		do
		begin
			@(posedge clock);
			if (arready)
				arvalid <= 1'h0;
		end
		while (!rvalid);
		rd = rdata;
		resp = rresp;
		rready <= 1'h0;
	endtask

	// Start a transfer, wait for its done interrupt, acknowledge it
	// Go is dropped while the gap runs, so wait for idle first
	task automatic idle;
		do
			axr(REG_STAT);
		while (rd[STAT_BUSY]);
	endtask

	task automatic xfer(input logic [7:0] cmd, input logic [1:0] pm);
		idle();
		axw(REG_CTRL, {16'h0000, cmd, 4'h0, pm, 2'h1});
		while (!irq)
			@(posedge clock);
		axw(REG_IRQS, 32'h0000_0001);
	endtask

	task automatic conv(input logic [DATA_W-1:0] d);
		@(posedge clock);
		convValid <= 1'h1;
		convData <= d;
		@(posedge clock);
		convValid <= 1'h0;
	endtask

	function automatic int hiCyc(input logic [1:0] pm);
		return (pm == 2'h1 ? RDYHI_MID_US : pm == 2'h2 ? RDYHI_LOW_US :
			RDYHI_FULL_US) * 1000 / CLK_NS;
	endfunction

	initial
	begin
		logic [1:0]  pm;
		logic [23:0] want;
		int          n, k;
		repeat (20) @(posedge clock);
		nrst <= 1'h1;
		@(negedge clock);
		`CHK("readyN", 1'h1, readyN)
		axw(REG_IRQM, 32'h0000_0001);
		foreach (rows[i])
		begin
			pm = rows[i].cfg[1:0];
			axw(REG_TXD, 32'(rows[i].cfg));
			xfer(8'h01, pm);
			`CHK("mode", rows[i].cfg[3:0], {cfgConvMode, cfgPowerMode})
			conv(~rows[i].data);
			conv(rows[i].data);
			n = 0;
			do
			begin
				@(negedge clock);
				n++;
			end
			while (readyN && n < 3000);
			// Typical figure only, so a small window is allowed
			`CHK("hiTime", 1'h1, n >= hiCyc(pm) - 2 && n <= hiCyc(pm) + 2)
			`CHK("readyN", 1'h0, readyN)
			k = takenCnt;
			xfer(8'h42, pm);
			axr(REG_RXD);
			`CHK("rxd", rows[i].data, rd[23:0])
			`CHK("taken", k + 1, takenCnt)
			`CHK("readyN", 1'h1, readyN)
			if (rows[i].cfg[CFG_HOLD_BIT])
				`CHK("holdLow", afterCnt, zeroCnt)
			else if (rows[i].cfg[CFG_DLY_BIT])
				`CHK("dlyLow", 1'h1, zeroCnt * CLK_NS >= SW_EXT_NS)
			else
				`CHK("plainLow", 1'h1, zeroCnt * CLK_NS < SW_EXT_NS)
			// No result update arrives during the reread
			xfer(8'h42, pm);
			axr(REG_RXD);
			want = rows[i].cfg[3:2] == 2'h2 ? 24'hFF_FFFF : rows[i].data;
			`CHK("reread", want, rd[23:0])
		end
		// Sync event stays masked until its mask bit is opened
		idle();
		axw(REG_CTRL, 32'h0000_0002);
		n = 0;
		while (syncCnt == 0 && n < 300)
		begin
			@(posedge clock);
			n++;
		end
		`CHK("syncs", 1, syncCnt)
		axr(REG_IRQS);
		`CHK("irqs", 2'h2, rd[1:0])
		`CHK("irqMasked", 1'h0, irq)
		axw(REG_IRQM, 32'h0000_0003);
		repeat (2) @(negedge clock);
		`CHK("irqOn", 1'h1, irq)
		axw(REG_IRQS, 32'h0000_0002);
		repeat (2) @(negedge clock);
		`CHK("irqOff", 1'h0, irq)
		axw(8'h20, 32'h0000_0001);
		`CHK("respW", RESP_SLVERR, resp)
		axr(8'h20);
		`CHK("respR", RESP_SLVERR, resp)
		`CHK("rdBad", 32'h0000_0000, rd)
		// Empty strobe must leave the register alone
		wstrb <= 4'h0;
		axw(REG_TXD, 32'h0000_00AA);
		wstrb <= 4'hF;
		axr(REG_TXD);
		`CHK("noStrb", 32'h0000_0008, rd)
		// Mid-run reset must clear the stored configuration
		@(posedge clock);
		nrst <= 1'h0;
		repeat (2) @(posedge clock);
		nrst <= 1'h1;
		@(negedge clock);
		`CHK("rstCfg", 4'h0, {cfgConvMode, cfgPowerMode})
		`CHK("rstReady", 1'h1, readyN)
		`CHK("rstIrq", 1'h0, irq)
		results();
	end
endmodule // serial_port_ready_signalling_tb
